// >>> rtl/sbsc_cfg.svh
// Constants for the stepper bridge serial control block.
// Included by the package and the top module; definitions only.
`ifndef SBSC_CFG_SVH
`define SBSC_CFG_SVH

`define SBSC_WORD_W 19
`define SBSC_SEL_BIT 0
`define SBSC_DAC1_LSB 1
`define SBSC_DAC2_LSB 7
`define SBSC_DAC_W 6
`define SBSC_PH1_BIT 13
`define SBSC_PH2_BIT 14
`define SBSC_MODE1_BIT 15
`define SBSC_MODE2_BIT 16
`define SBSC_REF_BIT 17
`define SBSC_RANGE_BIT 18
`define SBSC_WORD_RST 19'h0_0000
`define SBSC_SYS_CLK_HZ 20000000
`define SBSC_OSC_HZ 4000000
`define SBSC_OSC_DIV (`SBSC_SYS_CLK_HZ / `SBSC_OSC_HZ)
`define SBSC_BITCNT_W 5

`endif

// >>> rtl/sbsc_pkg.sv
// Types for the stepper bridge serial control block.
// Assumes sbsc_cfg.svh is on the include path.
`include "sbsc_cfg.svh"

package sbsc_pkg;

  typedef logic [`SBSC_WORD_W-1:0] sbsc_word_t;

  // Decoded bridge-control word.
  typedef struct packed {
    logic range_div4;
    logic ref_external;
    logic mode2_slow;
    logic mode1_slow;
    logic phase2;
    logic phase1;
    logic [`SBSC_DAC_W-1:0] dac2;
    logic [`SBSC_DAC_W-1:0] dac1;
  } sbsc_ctrl_t;

  // Drive state of one full bridge.
  typedef struct packed {
    logic enable;
    logic out_a;
    logic out_b;
    logic slow_decay;
    logic [`SBSC_DAC_W-1:0] level;
  } sbsc_bridge_t;

  // Synchronised serial pins.
  typedef struct packed {
    logic clk;
    logic data;
    logic strobe;
  } sbsc_pins_t;

  typedef enum logic [1:0] {
    SBSC_ST_SLEEP = 2'b00,
    SBSC_ST_RUN = 2'b01
  } sbsc_state_t;

endpackage

// >>> rtl/sbsc_sync.sv
// Two-stage synchroniser for the three serial pins.
// Assumes the pins are asynchronous to sys_clk_i.
`timescale 1ns/1ps

module sbsc_sync
  import sbsc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire sbsc_pins_t pins_i,
  output sbsc_pins_t pins_o
);

  typedef struct packed {
    sbsc_pins_t meta;
    sbsc_pins_t sync;
  } sbsc_sync_state_t;

  sbsc_sync_state_t s_q;
  sbsc_sync_state_t s_d;

  always_comb begin
    s_d.meta = pins_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o = s_q.sync;

endmodule

// >>> rtl/sbsc_top.sv
// Serial control front end of a dual full-bridge stepper driver.
// Assumes serial pins and sleep come from outside the sys_clk_i domain.
// The host must hold each pin level for at least two system cycles and
// leave two cycles between its last clock rise and the strobe.
//
// Functional notes
// - Configuration enters only over serial clock, data and strobe.
// - Each transfer carries one 19-bit word; two words exist.
// - Bit 0 selects the word; zero routes data to bridge control.
// - Most significant bit arrives first; the last bit is bit 0.
// - Bits 1 to 6 are the first bridge current code.
// - First bridge code zero disables that bridge, all drivers off.
// - Bits 7 to 12 are the second bridge current code.
// - Second bridge code zero disables that bridge, all drivers off.
// - Bit 13 sets first bridge direction: 0 gives A low, B high.
// - Bit 14 sets second bridge direction: 0 gives A low, B high.
// - Bits 15 and 16 pick decay: 0 mixed, 1 slow.
// - Bit 17 picks reference: 0 internal 2 V, 1 external.
// - Bit 18 picks range divider: 0 divide by eight, 1 by four.
// - Each code step changes target current by one sixty-fourth.
// - Digital timing comes from a nominal 4 MHz oscillator tick.
// - Sleep low clears both words and every output except the oscillator tick.
`timescale 1ns/1ps
`include "sbsc_cfg.svh"

module sbsc_top
  import sbsc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_strobe_i,
  input wire logic sleep_n_i,
  output logic first_bridge_output_a_o,
  output logic first_bridge_output_b_o,
  output logic second_bridge_output_a_o,
  output logic second_bridge_output_b_o,
  output logic first_bridge_enable_o,
  output logic second_bridge_enable_o,
  output logic [`SBSC_DAC_W-1:0] first_bridge_level_o,
  output logic [`SBSC_DAC_W-1:0] second_bridge_level_o,
  output logic first_bridge_slow_decay_o,
  output logic second_bridge_slow_decay_o,
  output logic ref_external_o,
  output logic range_div4_o,
  output logic [`SBSC_WORD_W-1:0] bridge_control_word_o,
  output logic [`SBSC_WORD_W-1:0] timing_word_o,
  output logic osc_tick_o
);

  // The tick divider assumes the system clock is an exact multiple of
  // the oscillator rate; any remainder would simply be dropped.
  localparam int unsigned OscDiv = `SBSC_OSC_DIV;
  localparam logic [2:0] OscLast = 3'(OscDiv - 1);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    sbsc_state_t state;
    logic sclk_prev;
    logic strobe_prev;
    logic sleep_meta;
    logic sleep_sync;
    sbsc_word_t shift;
    sbsc_word_t word0;
    sbsc_word_t word1;
    // Decoded drive settings are registered again, so they lag the
    // stored word by one cycle.
    sbsc_bridge_t br1;
    sbsc_bridge_t br2;
    logic ref_ext;
    logic range4;
    logic [2:0] osc_cnt;
    logic osc_tick;
  } sbsc_top_state_t;

  sbsc_top_state_t s_q;
  sbsc_top_state_t s_d;
  sbsc_pins_t pins_raw;
  sbsc_pins_t pins;
  sbsc_ctrl_t ctrl;

  assign pins_raw = '{
    clk: ser_clk_i,
    data: ser_data_i,
    strobe: ser_strobe_i
  };

  // Only the three serial wires carry configuration.
  sbsc_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .pins_i(pins_raw),
    .pins_o(pins)
  );

  assign ctrl = sbsc_ctrl_t'(s_q.word0[`SBSC_WORD_W-1:1]);

  // ==========================================================
  // Bridge decode
  // ==========================================================
  // Both bridges decode the same way from their own fields, so one
  // loop body serves both and the two cannot drift apart.
  logic [1:0][`SBSC_DAC_W-1:0] br_code;
  logic [1:0] br_phase;
  logic [1:0] br_slow;
  sbsc_bridge_t br_next [2];

  assign br_code = {ctrl.dac2, ctrl.dac1};
  assign br_phase = {ctrl.phase2, ctrl.phase1};
  assign br_slow = {ctrl.mode2_slow, ctrl.mode1_slow};

  for (genvar b = 0; b < 2; b++) begin : g_bridge
    logic active;
    // Sleep turns the drivers off at once instead of waiting for the
    // cleared word to reach the decode a cycle later.
    assign active = (br_code[b] != '0) && s_q.sleep_sync;
    // Codes pass straight to the DACs; each step is 1/64 of full
    // scale, so no scaling happens here.
    assign br_next[b] = '{
      enable: active,
      out_a: active && br_phase[b],
      out_b: active && !br_phase[b],
      slow_decay: br_slow[b],
      level: br_code[b]
    };
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    s_d = s_q;
    s_d.sclk_prev = pins.clk;
    s_d.strobe_prev = pins.strobe;
    // The sleep pin is asynchronous, so it passes two flops first.
    s_d.sleep_meta = sleep_n_i;
    s_d.sleep_sync = s_q.sleep_meta;

    // The divider gives a one-cycle tick at the nominal internal
    // oscillator rate; downstream PWM timing counts these ticks.
    if (s_q.osc_cnt == OscLast) begin
      s_d.osc_cnt = 3'h0;
      s_d.osc_tick = 1'b1;
    end else begin
      s_d.osc_cnt = s_q.osc_cnt + 3'h1;
      s_d.osc_tick = 1'b0;
    end

    case (s_q.state)
      SBSC_ST_SLEEP: begin
        s_d.shift = `SBSC_WORD_RST;
        s_d.word0 = `SBSC_WORD_RST;
        s_d.word1 = `SBSC_WORD_RST;
        if (s_q.sleep_sync) begin
          s_d.state = SBSC_ST_RUN;
        end
      end
      SBSC_ST_RUN: begin
        if (pins.clk && !s_q.sclk_prev) begin
          // New bits enter at bit 0, so the first bit ends in bit 18.
          s_d.shift = {s_q.shift[`SBSC_WORD_W-2:0], pins.data};
        end
        // A strobe in the same cycle as a clock edge loads the word as it
        // stood before that bit, so the host must finish clocking first.
        if (pins.strobe && !s_q.strobe_prev) begin
          if (s_q.shift[`SBSC_SEL_BIT] == 1'b0) begin
            s_d.word0 = s_q.shift;
          end else begin
            s_d.word1 = s_q.shift;
          end
        end
        // Sleep is handled last so it wins over a strobe in the same
        // cycle; no word can survive into sleep.
        if (!s_q.sleep_sync) begin
          s_d.state = SBSC_ST_SLEEP;
          s_d.shift = `SBSC_WORD_RST;
          s_d.word0 = `SBSC_WORD_RST;
          s_d.word1 = `SBSC_WORD_RST;
        end
      end
      default: begin
        // An illegal state code falls back to sleep, which clears words.
        s_d.state = SBSC_ST_SLEEP;
      end
    endcase

    s_d.br1 = br_next[0];
    s_d.br2 = br_next[1];
    s_d.ref_ext = ctrl.ref_external;
    s_d.range4 = ctrl.range_div4;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign first_bridge_output_a_o = s_q.br1.out_a;
  assign first_bridge_output_b_o = s_q.br1.out_b;
  assign second_bridge_output_a_o = s_q.br2.out_a;
  assign second_bridge_output_b_o = s_q.br2.out_b;
  assign first_bridge_enable_o = s_q.br1.enable;
  assign second_bridge_enable_o = s_q.br2.enable;
  assign first_bridge_level_o = s_q.br1.level;
  assign second_bridge_level_o = s_q.br2.level;
  assign first_bridge_slow_decay_o = s_q.br1.slow_decay;
  assign second_bridge_slow_decay_o = s_q.br2.slow_decay;
  assign ref_external_o = s_q.ref_ext;
  assign range_div4_o = s_q.range4;
  assign bridge_control_word_o = s_q.word0;
  assign timing_word_o = s_q.word1;
  assign osc_tick_o = s_q.osc_tick;

endmodule

// >>> verification/sbsc_top_asserts.sv
// Checker for the serial control block, watching its ports only.
// Assumes the decoded outputs follow the stored word by one cycle.
`timescale 1ns/1ps
module sbsc_chk (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sleep_n_i,
  input wire logic first_bridge_output_a_o,
  input wire logic first_bridge_output_b_o,
  input wire logic second_bridge_output_a_o,
  input wire logic second_bridge_output_b_o,
  input wire logic first_bridge_enable_o,
  input wire logic second_bridge_enable_o,
  input wire logic [5:0] first_bridge_level_o,
  input wire logic [5:0] second_bridge_level_o,
  input wire logic first_bridge_slow_decay_o,
  input wire logic second_bridge_slow_decay_o,
  input wire logic ref_external_o,
  input wire logic range_div4_o,
  input wire logic [18:0] bridge_control_word_o,
  input wire logic osc_tick_o
);
  // ======
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_lvl; {second_bridge_level_o, first_bridge_level_o} ==
    $past(bridge_control_word_o[12:1]); endproperty
  a_lvl: assert property (p_lvl) else $error("lvl");
  property p_mode; {range_div4_o, ref_external_o, second_bridge_slow_decay_o,
    first_bridge_slow_decay_o} == $past(bridge_control_word_o[18:15]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_off1; $past(bridge_control_word_o[6:1]) == 6'h0
    |-> !first_bridge_output_a_o && !first_bridge_output_b_o; endproperty
  a_off1: assert property (p_off1) else $error("off1");
  property p_off2; $past(bridge_control_word_o[12:7]) == 6'h0
    |-> !second_bridge_output_a_o && !second_bridge_output_b_o; endproperty
  a_off2: assert property (p_off2) else $error("off2");
  property p_ph1; first_bridge_enable_o |-> first_bridge_output_b_o !=
    first_bridge_output_a_o && first_bridge_output_a_o ==
    $past(bridge_control_word_o[13]); endproperty
  a_ph1: assert property (p_ph1) else $error("ph1");
  property p_ph2; second_bridge_enable_o |-> second_bridge_output_b_o !=
    second_bridge_output_a_o && second_bridge_output_a_o ==
    $past(bridge_control_word_o[14]); endproperty
  a_ph2: assert property (p_ph2) else $error("ph2");
  property p_osc; osc_tick_o |=> !osc_tick_o [*4] ##1 osc_tick_o; endproperty
  a_osc: assert property (p_osc) else $error("osc");
  property p_slp; !sleep_n_i [*4] |-> bridge_control_word_o == 19'h0;
  endproperty
  a_slp: assert property (p_slp) else $error("slp");
endmodule
bind sbsc_top sbsc_chk chk (.*);

// >>> verification/sbsc_host.sv
// Host model driving the three-wire serial port.
// Assumes send is called by the bench just after a falling clock edge.
`timescale 1ns/1ps
module sbsc_host (
  input wire logic sys_clk_i,
  output logic clk_o,
  output logic dat_o,
  output logic stb_o
);
  initial {clk_o, dat_o, stb_o} = 3'h0;
  // ======
  // Frame: serial clock idles low, 400 ns per bit.
  task automatic send(input logic [18:0] w);
    for (int i = 18; i >= 0; i--) begin
      clk_o = 1'b0;
      dat_o = w[i];
      repeat (4) @(negedge sys_clk_i);
      clk_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
    end
    clk_o = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    stb_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    stb_o = 1'b0;
    // A released line must not keep showing the last bit.
    dat_o = ~dat_o;
  endtask
endmodule

// >>> verification/sbsc_tb_top.sv
// Bench for the serial control block with a host model.
// Assumes design, host model and checker are compiled before it.
`timescale 1ns/1ps
module stepper_bridge_serial_control_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, sleep_n = 1'b1;
  logic sck, sda, sst, a1, b1, a2, b2, e1, e2, s1, s2, rf, rg, tk;
  logic [5:0] l1, l2;
  logic [18:0] w0, w1;
  logic [18:0] t [5] = '{19'h7_FFFE, 19'h0_0002, 19'h4_4080, 19'h0_0000,
    19'h2_A55A};
  int err_total = 0, total_checks = 0, cyc = 0;
  wire [21:0] obs = {a1, b1, a2, b2, e1, e2, l1, l2, s1, s2, rf, rg};
  always #25 clk = ~clk;
  sbsc_host host (.sys_clk_i(clk), .clk_o(sck), .dat_o(sda), .stb_o(sst));
  sbsc_top DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .ser_clk_i(sck),
    .ser_data_i(sda), .ser_strobe_i(sst), .sleep_n_i(sleep_n),
    .first_bridge_output_a_o(a1), .first_bridge_output_b_o(b1),
    .second_bridge_output_a_o(a2), .second_bridge_output_b_o(b2),
    .first_bridge_enable_o(e1), .second_bridge_enable_o(e2),
    .first_bridge_level_o(l1), .second_bridge_level_o(l2),
    .first_bridge_slow_decay_o(s1), .second_bridge_slow_decay_o(s2),
    .ref_external_o(rf), .range_div4_o(rg), .bridge_control_word_o(w0),
    .timing_word_o(w1), .osc_tick_o(tk));
  task automatic chk(input string n, input logic [21:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [21:0] dec(input logic [18:0] w);
    logic n1, n2;
    n1 = |w[6:1];
    n2 = |w[12:7];
    return {n1 & w[13], n1 & ~w[13], n2 & w[14], n2 & ~w[14], n1, n2,
      w[6:1], w[12:7], w[15], w[16], w[17], w[18]};
  endfunction
  task automatic chk_tick();
    int n = 0;
    repeat (50) begin
      @(negedge clk);
      n += tk;
    end
    chk("tick", 22'h0_000A, 22'(n));
  endtask
  task automatic put(input logic [18:0] w);
    host.send(w);
    repeat (2) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("reset", 22'h0, obs);
    chk_tick();
    $display("test reset done");
    foreach (t[i]) begin
      put(t[i]);
      chk("word0", t[i], w0);
      chk("out", dec(t[i]), obs);
    end
    $display("test decode done");
    put(19'h5_3579);
    chk("word1", 19'h5_3579, w1);
    chk("kept", t[4], w0);
    $display("test select done");
    sleep_n = 1'b0;
    put(19'h7_FFFE);
    chk("sleep0", 22'h0, w0);
    chk("sleep1", 22'h0, w1);
    chk("sleepo", 22'h0, obs);
    sleep_n = 1'b1;
    repeat (6) @(negedge clk);
    put(19'h0_0002);
    chk("wake", dec(19'h0_0002), obs);
    $display("test sleep done");
    wrap_up();
  end
endmodule
